/* common/flash_cfg_consts.vh */
// Constants for the flash configuration and error-control register bank.
// Assumes inclusion by bare name from files that need offsets and fields.
`ifndef FLASH_CFG_CONSTS_VH
`define FLASH_CFG_CONSTS_VH

// Byte offsets on the register bus
`define OFS_FLASH_CONFIG 8'h00
`define OFS_FLASH_ERROR_CONFIG 8'h04
`define OFS_FLASH_STATUS 8'h08
`define OFS_FLASH_ERROR_STATUS 8'h0C
`define OFS_ECC_ERROR_CAPTURE 8'h10

// flash_config field positions
`define BIT_CMD_DONE_IRQ_ENABLE 7
`define BIT_IGNORE_SINGLE_FAULT 4
`define BIT_FORCE_DOUBLE_FAULT 1
`define BIT_FORCE_SINGLE_FAULT 0
`define MASK_FLASH_CONFIG 8'h93

// flash_error_config field positions
`define BIT_DOUBLE_FAULT_IRQ_ENABLE 1
`define BIT_SINGLE_FAULT_IRQ_ENABLE 0
`define MASK_FLASH_ERROR_CONFIG 8'h03

// flash_status and flash_error_status field positions
`define BIT_CMD_DONE_FLAG 7
`define BIT_DOUBLE_FAULT_FLAG 1
`define BIT_SINGLE_FAULT_FLAG 0

// Reset values
`define RST_FLASH_CONFIG 8'h00
`define RST_FLASH_ERROR_CONFIG 8'h00
`define RST_FLASH_ERROR_STATUS 2'h0
`define RST_CMD_DONE_FLAG 1'h1
`define RST_ECC_ERROR_CAPTURE 32'h00000000

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* design/fault_event_logic.v */
// Per-read fault decision: which fault flags an array read sets and whether
// the capture register loads. Assumes one read-done pulse per array read.
`default_nettype none

module fault_event_logic (
   // Array read event and its ECC result
   input wire rd_done,
   input wire ecc_single,
   input wire ecc_double,
   input wire rd_collision,
   // Configuration bits
   input wire ignore_single_fault,
   input wire force_single_fault,
   input wire force_double_fault,
   // Decisions
   output reg set_single,
   output reg set_double,
   output reg capture_en
);

   // Decision for one read; all terms idle without rd_done
   always @* begin
      set_single = 1'b0;
      set_double = 1'b0;
      capture_en = 1'b0;
      if (rd_done) begin
         if (rd_collision) begin
            set_single = 1'b1;
            set_double = 1'b1;
         end else begin
            set_double = ecc_double | force_double_fault;
            set_single = ~ignore_single_fault & (ecc_single | force_single_fault);
            capture_en = ecc_double | (ecc_single & ~ignore_single_fault);
         end
      end
   end

endmodule // fault_event_logic

`default_nettype wire

/* design/axil_reg_port.v */
// AXI4-Lite slave front end: takes address and data in either order, gives
// one write strobe and one read strobe. Assumes the top decodes addresses.
`default_nettype none
`include "flash_cfg_consts.vh"

module axil_reg_port (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Write address channel
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // Write data channel
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // Write response channel
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // Read address channel
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // Read data channel
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Register side
   output wire wr_en,
   output wire [7:0] wr_addr,
   output wire [31:0] wr_data,
   output wire [3:0] wr_strb,
   input wire wr_err,
   output wire rd_en,
   output wire [7:0] rd_addr,
   input wire [31:0] rd_data,
   input wire rd_err
);

   reg aw_held_reg;
   reg w_held_reg;
   reg [7:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;

   // Each half is taken once and held until the response goes out
   assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
   assign wr_en = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign wr_addr = awaddr_reg;
   assign wr_data = wdata_reg;
   assign wr_strb = wstrb_reg;

   // Reads wait until the previous answer is accepted
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_en = s_axi_arvalid & s_axi_arready;
   assign rd_addr = s_axi_araddr;

   // Write channel state
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel state; data sampled when the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (rd_en) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // axil_reg_port

`default_nettype wire

/* design/flash_cfg_err_ctrl.v */
// Flash configuration and error-control register bank with its interrupt
// requests. Assumes a command sequencer reports busy and an ECC checker
// reports one pulse per array read with its fault result.
`default_nettype none
`include "flash_cfg_consts.vh"

module flash_cfg_err_ctrl (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // Command sequencer
   input wire cmd_busy,
   // Array read result from the ECC checker
   input wire array_rd_done,
   input wire [31:0] array_rd_addr,
   input wire ecc_single,
   input wire ecc_double,
   input wire rd_collision,
   // Interrupt requests
   output wire cmd_done_irq,
   output wire double_fault_irq,
   output wire single_fault_irq,
   // Configuration seen by the array read path
   output wire ignore_single_fault,
   output wire force_single_fault,
   output wire force_double_fault
);

   // Bus side signals
   wire wr_en;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire rd_en;
   wire [7:0] rd_addr;
   reg [31:0] rd_data;
   reg rd_err;
   reg wr_err;

   // Register state
   reg [7:0] flash_config_reg;
   reg [7:0] flash_config_next;
   reg [7:0] flash_error_config_reg;
   reg [7:0] flash_error_config_next;
   reg cmd_done_flag_reg;
   reg double_fault_flag_reg;
   reg double_fault_flag_next;
   reg single_fault_flag_reg;
   reg single_fault_flag_next;
   reg [31:0] ecc_error_capture_reg;
   reg [31:0] ecc_error_capture_next;

   // Fault decisions for the current read
   wire set_single;
   wire set_double;
   wire capture_en;

   // Byte-lane-0 write strobes per register
   wire lane0_wr;
   wire cfg_wr;
   wire err_cfg_wr;
   wire err_stat_wr;

   // Enable fields
   wire cmd_done_irq_enable;
   wire double_fault_irq_enable;
   wire single_fault_irq_enable;

   axil_reg_port u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   fault_event_logic u_fault (
      .rd_done(array_rd_done),
      .ecc_single(ecc_single),
      .ecc_double(ecc_double),
      .rd_collision(rd_collision),
      .ignore_single_fault(ignore_single_fault),
      .force_single_fault(force_single_fault),
      .force_double_fault(force_double_fault),
      .set_single(set_single),
      .set_double(set_double),
      .capture_en(capture_en)
   );

   // Field views of the configuration registers
   assign cmd_done_irq_enable = flash_config_reg[`BIT_CMD_DONE_IRQ_ENABLE];
   assign ignore_single_fault = flash_config_reg[`BIT_IGNORE_SINGLE_FAULT];
   assign force_double_fault = flash_config_reg[`BIT_FORCE_DOUBLE_FAULT];
   assign force_single_fault = flash_config_reg[`BIT_FORCE_SINGLE_FAULT];
   assign double_fault_irq_enable = flash_error_config_reg[`BIT_DOUBLE_FAULT_IRQ_ENABLE];
   assign single_fault_irq_enable = flash_error_config_reg[`BIT_SINGLE_FAULT_IRQ_ENABLE];

   // Writable registers are 8 bits wide, so only lane 0 carries data
   assign lane0_wr = wr_en & wr_strb[0];
   assign cfg_wr = lane0_wr & (wr_addr == `OFS_FLASH_CONFIG);
   assign err_cfg_wr = lane0_wr & (wr_addr == `OFS_FLASH_ERROR_CONFIG);
   assign err_stat_wr = lane0_wr & (wr_addr == `OFS_FLASH_ERROR_STATUS);

   // Write decode; unmapped addresses answer with an error
   always @* begin
      case (wr_addr)
         `OFS_FLASH_CONFIG: wr_err = 1'b0;
         `OFS_FLASH_ERROR_CONFIG: wr_err = 1'b0;
         `OFS_FLASH_STATUS: wr_err = 1'b0; // Read-only, write ignored
         `OFS_FLASH_ERROR_STATUS: wr_err = 1'b0;
         `OFS_ECC_ERROR_CAPTURE: wr_err = 1'b0; // Read-only, write ignored
         default: wr_err = 1'b1;
      endcase
   end

   // Configuration next values
   always @* begin
      flash_config_next = flash_config_reg;
      flash_error_config_next = flash_error_config_reg;
      if (cfg_wr) begin
         flash_config_next = wr_data[7:0] & `MASK_FLASH_CONFIG;
      end
      if (err_cfg_wr) begin
         flash_error_config_next = wr_data[7:0] & `MASK_FLASH_ERROR_CONFIG;
      end
   end

   // Fault flag next values; a new fault wins over a same-cycle clear
   always @* begin
      double_fault_flag_next = double_fault_flag_reg;
      single_fault_flag_next = single_fault_flag_reg;
      if (err_stat_wr && wr_data[`BIT_DOUBLE_FAULT_FLAG]) begin
         double_fault_flag_next = 1'b0;
      end
      if (err_stat_wr && wr_data[`BIT_SINGLE_FAULT_FLAG]) begin
         single_fault_flag_next = 1'b0;
      end
      if (set_double) begin
         double_fault_flag_next = 1'b1;
      end
      if (set_single) begin
         single_fault_flag_next = 1'b1;
      end
   end

   // Capture keeps the address of the last ECC double fault or non-ignored single fault outside a collision
   always @* begin
      ecc_error_capture_next = ecc_error_capture_reg;
      if (capture_en) begin
         ecc_error_capture_next = array_rd_addr;
      end
   end

   // State registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         flash_config_reg <= `RST_FLASH_CONFIG;
         flash_error_config_reg <= `RST_FLASH_ERROR_CONFIG;
         // Command done reads as idle out of reset
         cmd_done_flag_reg <= `RST_CMD_DONE_FLAG;
         {double_fault_flag_reg, single_fault_flag_reg} <= `RST_FLASH_ERROR_STATUS;
         ecc_error_capture_reg <= `RST_ECC_ERROR_CAPTURE;
      end else begin
         flash_config_reg <= flash_config_next;
         flash_error_config_reg <= flash_error_config_next;
         cmd_done_flag_reg <= ~cmd_busy;
         double_fault_flag_reg <= double_fault_flag_next;
         single_fault_flag_reg <= single_fault_flag_next;
         ecc_error_capture_reg <= ecc_error_capture_next;
      end
   end

   // Read mux; reserved bits read as zero
   always @* begin
      rd_data = 32'h00000000;
      rd_err = 1'b0;
      case (rd_addr)
         `OFS_FLASH_CONFIG: rd_data[7:0] = flash_config_reg;
         `OFS_FLASH_ERROR_CONFIG: rd_data[7:0] = flash_error_config_reg;
         `OFS_FLASH_STATUS: rd_data[`BIT_CMD_DONE_FLAG] = cmd_done_flag_reg;
         `OFS_FLASH_ERROR_STATUS: begin
            rd_data[`BIT_DOUBLE_FAULT_FLAG] = double_fault_flag_reg;
            rd_data[`BIT_SINGLE_FAULT_FLAG] = single_fault_flag_reg;
         end
         `OFS_ECC_ERROR_CAPTURE: rd_data = ecc_error_capture_reg;
         default: rd_err = 1'b1;
      endcase
   end

   // Interrupt levels follow flag and enable with no extra latency,
   // so clearing either drops the request at once
   // command done request
   assign cmd_done_irq = cmd_done_flag_reg & cmd_done_irq_enable;
   assign double_fault_irq = double_fault_flag_reg & double_fault_irq_enable;
   assign single_fault_irq = single_fault_flag_reg & single_fault_irq_enable;

endmodule // flash_cfg_err_ctrl

`default_nettype wire

/* test/flash_cfg_err_ctrl_props.sv */
// Checker for the flash config and error-control bank, bound to its top.
// Assumes one clock, synchronous active-low reset, level interrupt outputs.
`default_nettype none

module flash_cfg_err_ctrl_props (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Flash side
   input wire logic cmd_busy,
   input wire logic array_rd_done,
   input wire logic rd_collision,
   input wire logic cmd_done_irq,
   input wire logic double_fault_irq,
   input wire logic single_fault_irq,
   input wire logic ignore_single_fault,
   input wire logic force_single_fault,
   input wire logic force_double_fault
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Config bits move only with a completed write, never after reads
   cfg_hold_a: assert property (
      $changed({ignore_single_fault, force_double_fault, force_single_fault})
      |-> $rose(s_axi_bvalid)) else $error("config bit moved without a write");
   // Done flag lags busy by one cycle
   cmd_irq_a: assert property (
      cmd_done_irq |-> !$past(cmd_busy)) else $error("done irq while busy");
   // Ignored single faults stay silent unless a write intervenes
   ign_single_a: assert property (
      (ignore_single_fault && array_rd_done && !rd_collision && !single_fault_irq)
      ##1 !$rose(s_axi_bvalid) |-> !single_fault_irq)
      else $error("ignored single fault interrupted");
   dirq_rise_a: assert property (
      $rose(double_fault_irq) |-> $past(array_rd_done) || $rose(s_axi_bvalid))
      else $error("double irq rose without cause");
   // Flags drop only through software clears
   irq_fall_a: assert property (
      $fell(double_fault_irq) || $fell(single_fault_irq) |-> $rose(s_axi_bvalid))
      else $error("fault irq fell without a write");
   rd_lat_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   ar_block_a: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   b_done_a: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
   rst_cfg_a: assert property (
      $rose(aresetn) |-> !(ignore_single_fault | force_double_fault | force_single_fault
      | cmd_done_irq | double_fault_irq | single_fault_irq)) else $error("not cleared");

   cover property ($rose(double_fault_irq));
   cover property ($rose(cmd_done_irq));
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // flash_cfg_err_ctrl_props

bind flash_cfg_err_ctrl flash_cfg_err_ctrl_props props_u (.*);
`default_nettype wire

/* test/flash_cfg_err_ctrl_tb.sv */
// Self-checking bench for the flash config and error-control bank.
// Assumes the bus answers in time; only the watchdog ends a hung wait.
`default_nettype none

module flash_cfg_err_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic cmd_busy = 1'b0;
   logic array_rd_done = 1'b0;
   logic [31:0] array_rd_addr = 32'h0;
   logic ecc_single = 1'b0;
   logic ecc_double = 1'b0;
   logic rd_collision = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire cmd_done_irq, double_fault_irq, single_fault_irq;
   wire ignore_single_fault, force_single_fault, force_double_fault;
   // Model state, reset values
   logic [7:0] cfg = 8'h00;
   logic [1:0] ecfg = 2'h0;
   logic cmdf = 1'b1;
   logic dfl = 1'b0;
   logic sfl = 1'b0;
   logic [31:0] cap = 32'h0;
   logic [31:0] rnd = 32'h0000005F;
   int mismatches = 0;
   int total_checks = 0;

   flash_cfg_err_ctrl dut_u (.*);

   // 200 MHz clock
   always #2.5 aclk = ~aclk;

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Unmapped offsets answer with an error response
   function automatic logic [1:0] ok(input logic [7:0] a);
      return (a <= 8'h10) ? 2'h0 : 2'h2;
   endfunction

   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h00: return {24'h0, cfg};
         8'h04: return {30'h0, ecfg};
         8'h08: return {24'h0, cmdf, 7'h0};
         8'h0C: return {30'h0, dfl, sfl};
         8'h10: return cap;
         default: return 32'h0;
      endcase
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      if (mismatches == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Write: both halves offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bvalid), 32'h1);
      chk(32'(s_axi_bresp), 32'(ok(a)));
      // Lane 0 strobe low leaves every register as it was
      if (s_axi_wstrb[0]) begin
         case (a)
            8'h00: cfg = d[7:0] & 8'h93;
            8'h04: ecfg = d[1:0];
            8'h0C: {dfl, sfl} = {dfl, sfl} & ~d[1:0];
            default: ;
         endcase
      end
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(32'(s_axi_rresp), 32'(ok(a)));
      @(posedge aclk);
   endtask

   // Irq levels sampled at the edge show the previous settled cycle
   task automatic chk_all;
      logic [31:0] d;
      chk(32'(cmd_done_irq), 32'(cfg[7] & cmdf));
      chk(32'(double_fault_irq), 32'(ecfg[1] & dfl));
      chk(32'(single_fault_irq), 32'(ecfg[0] & sfl));
      chk(32'({ignore_single_fault, force_double_fault, force_single_fault}),
         32'({cfg[4], cfg[1], cfg[0]}));
      for (int a = 0; a <= 16; a += 4) begin
         rd(a[7:0], d);
         chk(d, exp_rd(a[7:0]));
      end
   endtask

   // One array read; faults decided by the model from config
   task automatic aread(input logic [2:0] f, input logic [31:0] ad);
      logic ig;
      ig = cfg[4];
      array_rd_done <= 1'b1;
      ecc_single <= f[0];
      ecc_double <= f[1];
      rd_collision <= f[2];
      array_rd_addr <= ad;
      @(posedge aclk);
      array_rd_done <= 1'b0;
      dfl |= f[2] | f[1] | cfg[1];
      sfl |= f[2] | (!ig & (f[0] | cfg[0]));
      if (!f[2] && (f[1] || (f[0] && !ig))) cap = ad;
      @(posedge aclk);
   endtask

   initial begin
      logic [31:0] d;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_all;
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, d);
      chk(d, exp_rd(8'h20));
      wr(8'h08, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      // Lane 0 strobe low: the write is answered but nothing moves
      s_axi_wstrb <= 4'hE;
      wr(8'h00, 32'h00000093);
      s_axi_wstrb <= 4'hF;
      chk_all;
      // Sweep ignore, both forces and every fault kind
      for (int i = 0; i < 64; i++) begin
         rnd = lfsr(rnd);
         wr(8'h00, {rnd[31:5], i[5], rnd[3:2], i[4:3]});
         wr(8'h04, rnd);
         wr(8'h0C, rnd >> 8);
         aread(i[2] ? 3'b100 : {1'b0, i[1], i[0] & ~i[1]}, rnd);
         chk_all;
      end
      // Done flag follows the sequencer busy level
      wr(8'h00, 32'h80);
      cmd_busy <= 1'b1;
      repeat (2) @(posedge aclk);
      cmdf = 1'b0;
      chk_all;
      cmd_busy <= 1'b0;
      repeat (2) @(posedge aclk);
      cmdf = 1'b1;
      chk_all;
      print_verdict;
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      print_verdict;
   end
endmodule // flash_cfg_err_ctrl_tb
`default_nettype wire
